// ==== design/status_mon_pkg.sv ====
// Operation
// - Code 08 selects serial watchdog; flag set when traffic pauses past timeout.
// - Serial flag stays clear while frames keep arriving before timeout.
// - Serial timeout applies chosen response: trip with E60 alarm, controlled stop or coast.
// - Code 09 picks two operands among nine other status functions by selects.
// - Operands combined by AND, OR or XOR per operator select.
// - Combination output ON for result one, OFF for result zero.
// - Code 10 selects option watchdog with its own timeout period.
// - Option flag ON only after period expires, OFF while option traffic continues.
// - Code 43 sets light load flag when current below threshold.
// - Light load flag clear when current above threshold.
package status_mon_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_SER_TO  = 8'h04;
  localparam logic [7:0] ADDR_OPT_TO  = 8'h08;
  localparam logic [7:0] ADDR_THRESH  = 8'h0C;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h18;

  // Control field positions
  localparam int CTRL_OUT_SEL_LSB = 0;
  localparam int CTRL_RESP_LSB    = 8;
  localparam int CTRL_OPA_LSB     = 12;
  localparam int CTRL_OPB_LSB     = 16;
  localparam int CTRL_OPER_LSB    = 20;

  // Reset values
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0008;
  localparam logic [31:0] SER_TO_RESET = 32'h0000_0000;
  localparam logic [31:0] OPT_TO_RESET = 32'h0000_0000;
  localparam logic [15:0] THR_RESET    = 16'h0000;

  // One watchdog tick in microseconds
  localparam int TICK_US      = 10;
  localparam int CLK_MHZ      = 250;
  localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;

  // Output selection codes
  localparam logic [7:0] SEL_SERIAL = 8'h08;
  localparam logic [7:0] SEL_COMBO  = 8'h09;
  localparam logic [7:0] SEL_OPTION = 8'h0A;
  localparam logic [7:0] SEL_LIGHT  = 8'h2B;

  // Alarm code for serial link loss
  localparam logic [7:0] ALARM_CODE_LINK = 8'h3C;

  typedef enum logic [1:0] {
    RESP_TRIP      = 2'b00,
    RESP_TRIP_STOP = 2'b01,
    RESP_NONE      = 2'b10,
    RESP_FREE_RUN  = 2'b11
  } resp_t;

  typedef enum logic [1:0] {
    OPER_AND = 2'b00,
    OPER_OR  = 2'b01,
    OPER_XOR = 2'b10
  } oper_t;

  typedef struct packed {
    logic        alarm;
    logic [7:0]  alarm_code;
    logic        decel_stop;
    logic        coast_stop;
  } resp_out_t;

endpackage

// ==== design/status_output_monitors.sv ====
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module status_output_monitors #(
  parameter int TICK = status_mon_pkg::TICK_CYCLES
) (
  input  wire logic                      clk_in,
  input  wire logic                      sys_rst_in,
  input  wire logic [7:0]                avs_address_in,
  input  wire logic                      avs_read_in,
  input  wire logic                      avs_write_in,
  input  wire logic [31:0]               avs_writedata_in,
  input  wire logic [3:0]                avs_byteenable_in,
  output logic      [31:0]               avs_readdata_out,
  output logic                           avs_waitrequest_out,
  input  wire logic                      serial_frame_in,
  input  wire logic                      option_frame_in,
  input  wire logic [15:0]               current_in,
  input  wire logic [8:0]                other_status_in,
  output logic                           status_out,
  output status_mon_pkg::resp_out_t      resp_out,
  output logic                           irq_out
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0]               ctrl;
    logic [31:0]               ser_to;
    logic [31:0]               opt_to;
    logic [15:0]               thresh;
    logic [15:0]               tick_cnt;
    logic [31:0]               ser_cnt;
    logic [31:0]               opt_cnt;
    logic                      ser_loss;
    logic                      opt_loss;
    logic                      light;
    logic                      combo;
    logic                      status;
    status_mon_pkg::resp_out_t resp;
    logic [3:0]                irq_st;
    logic [3:0]                irq_msk;
    logic                      ack;
    logic [31:0]               rdata;
  } state_t;

  state_t st;
  state_t next_st;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic pick(input logic [3:0] sel, input logic [8:0] v);
    logic r;
    r = 1'b0;
    if (sel < 4'd9) begin
      r = v[sel];
    end
    return r;
  endfunction

  logic [7:0] out_sel;
  logic [1:0] resp_sel;
  logic       ser_expire;
  logic       opt_expire;
  logic       tick;
  logic       opa;
  logic       opb;
  logic       combo_val;
  logic [3:0] events;
  logic       access;

  assign out_sel  = st.ctrl[status_mon_pkg::CTRL_OUT_SEL_LSB +: 8];
  assign resp_sel = st.ctrl[status_mon_pkg::CTRL_RESP_LSB +: 2];
  assign tick     = (st.tick_cnt == 16'(TICK - 1));
  assign ser_expire = (st.ser_to != 32'h0000_0000) && (st.ser_cnt >= st.ser_to);
  assign opt_expire = (st.opt_to != 32'h0000_0000) && (st.opt_cnt >= st.opt_to);
  assign opa = pick(st.ctrl[status_mon_pkg::CTRL_OPA_LSB +: 4], other_status_in);
  assign opb = pick(st.ctrl[status_mon_pkg::CTRL_OPB_LSB +: 4], other_status_in);
  assign access = (avs_read_in || avs_write_in) && !st.ack;

  always_comb begin
    case (status_mon_pkg::oper_t'(st.ctrl[status_mon_pkg::CTRL_OPER_LSB +: 2]))
      status_mon_pkg::OPER_AND: combo_val = opa & opb;
      status_mon_pkg::OPER_OR:  combo_val = opa | opb;
      status_mon_pkg::OPER_XOR: combo_val = opa ^ opb;
      default:                  combo_val = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.tick_cnt = tick ? 16'h0000 : 16'(st.tick_cnt + 16'h0001);
    if (serial_frame_in) begin
      next_st.ser_cnt = 32'h0000_0000;
    end else if (tick && !ser_expire) begin
      next_st.ser_cnt = 32'(st.ser_cnt + 32'h0000_0001);
    end
    if (option_frame_in) begin
      next_st.opt_cnt = 32'h0000_0000;
    end else if (tick && !opt_expire) begin
      next_st.opt_cnt = 32'(st.opt_cnt + 32'h0000_0001);
    end
    next_st.ser_loss = ser_expire && !serial_frame_in;
    next_st.opt_loss = opt_expire && !option_frame_in;
    if (current_in < st.thresh) begin
      next_st.light = 1'b1;
    end else if (current_in > st.thresh) begin
      next_st.light = 1'b0;
    end
    next_st.combo = combo_val;
    case (out_sel)
      status_mon_pkg::SEL_SERIAL: next_st.status = st.ser_loss;
      status_mon_pkg::SEL_COMBO:  next_st.status = st.combo;
      status_mon_pkg::SEL_OPTION: next_st.status = st.opt_loss;
      status_mon_pkg::SEL_LIGHT:  next_st.status = st.light;
      default:                    next_st.status = 1'b0;
    endcase
    if (st.ser_loss && out_sel == status_mon_pkg::SEL_SERIAL) begin
      case (status_mon_pkg::resp_t'(resp_sel))
        status_mon_pkg::RESP_TRIP: begin
          next_st.resp.alarm      = 1'b1;
          next_st.resp.alarm_code = status_mon_pkg::ALARM_CODE_LINK;
          next_st.resp.coast_stop = 1'b1;
        end
        status_mon_pkg::RESP_TRIP_STOP: begin
          next_st.resp.alarm      = 1'b1;
          next_st.resp.alarm_code = status_mon_pkg::ALARM_CODE_LINK;
          next_st.resp.decel_stop = 1'b1;
        end
        status_mon_pkg::RESP_FREE_RUN: next_st.resp.coast_stop = 1'b1;
        default:                       next_st.resp.decel_stop = st.resp.decel_stop;
      endcase
    end
    // Bus access, one wait cycle
    next_st.ack = access;
    next_st.rdata = 32'h0000_0000;
    if (access && avs_write_in) begin
      case (avs_address_in)
        status_mon_pkg::ADDR_CTRL:    next_st.ctrl = merge(st.ctrl, avs_writedata_in, avs_byteenable_in);
        status_mon_pkg::ADDR_SER_TO:  next_st.ser_to = merge(st.ser_to, avs_writedata_in, avs_byteenable_in);
        status_mon_pkg::ADDR_OPT_TO:  next_st.opt_to = merge(st.opt_to, avs_writedata_in, avs_byteenable_in);
        status_mon_pkg::ADDR_THRESH:  next_st.thresh = 16'(merge({16'h0000, st.thresh}, avs_writedata_in,
                                                                 avs_byteenable_in));
        status_mon_pkg::ADDR_IRQ_MSK: next_st.irq_msk = 4'(merge({28'h0, st.irq_msk}, avs_writedata_in,
                                                                 avs_byteenable_in));
        default:                      next_st.ack = access;
      endcase
    end
    if (access && avs_read_in) begin
      case (avs_address_in)
        status_mon_pkg::ADDR_CTRL:    next_st.rdata = st.ctrl;
        status_mon_pkg::ADDR_SER_TO:  next_st.rdata = st.ser_to;
        status_mon_pkg::ADDR_OPT_TO:  next_st.rdata = st.opt_to;
        status_mon_pkg::ADDR_THRESH:  next_st.rdata = {16'h0000, st.thresh};
        status_mon_pkg::ADDR_STATUS:  next_st.rdata = {20'h0_0000, st.resp.alarm_code, st.combo, st.light,
                                                       st.opt_loss, st.ser_loss};
        status_mon_pkg::ADDR_IRQ_ST:  next_st.rdata = {28'h000_0000, st.irq_st};
        status_mon_pkg::ADDR_IRQ_MSK: next_st.rdata = {28'h000_0000, st.irq_msk};
        default:                      next_st.rdata = 32'h0000_0000;
      endcase
    end
    // Events from flag transitions
    events = {st.combo ^ next_st.combo, st.light ^ next_st.light,
              !st.opt_loss & next_st.opt_loss, !st.ser_loss & next_st.ser_loss};
    // Sticky events; set wins over read clear
    if (access && avs_read_in && avs_address_in == status_mon_pkg::ADDR_IRQ_ST) begin
      next_st.irq_st = events;
    end else begin
      next_st.irq_st = st.irq_st | events;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st        <= '0;
      st.ctrl   <= status_mon_pkg::CTRL_RESET;
      st.ser_to <= status_mon_pkg::SER_TO_RESET;
      st.opt_to <= status_mon_pkg::OPT_TO_RESET;
      st.thresh <= status_mon_pkg::THR_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata_out    = st.rdata;
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !st.ack;
  assign status_out          = st.status;
  assign resp_out            = st.resp;
  assign irq_out             = |(st.irq_st & st.irq_msk);

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_serial_frame_clear: assert property (serial_frame_in |=> !st.ser_loss)
    else $error("serial flag set after frame");
  a_serial_expire_set: assert property (ser_expire && !serial_frame_in |=> st.ser_loss)
    else $error("serial flag missing on expiry");
  a_option_expire_set: assert property (opt_expire && !option_frame_in |=> st.opt_loss)
    else $error("option flag missing on expiry");
  a_option_early_off: assert property (st.opt_loss |-> $past(opt_expire))
    else $error("option flag before expiry");
  a_frame_restart: assert property (option_frame_in |=> st.opt_cnt == 32'h0000_0000)
    else $error("option count not restarted");
  a_light_below: assert property (current_in < st.thresh |=> st.light)
    else $error("light flag missing");
  a_light_above: assert property (current_in > st.thresh |=> !st.light)
    else $error("light flag stuck");
  a_combo_level: assert property (out_sel == status_mon_pkg::SEL_COMBO |=> status_out == $past(st.combo))
    else $error("combo level wrong");
  a_combo_xor: assert property (st.ctrl[21:20] == 2'b10 |=> st.combo == $past(opa ^ opb))
    else $error("xor wrong");
  a_resp_trip: assert property (st.ser_loss && out_sel == status_mon_pkg::SEL_SERIAL && resp_sel == 2'b00
                                |=> resp_out.alarm && resp_out.coast_stop)
    else $error("trip response missing");
  a_operand_pick: assert property (st.ctrl[15:12] == 4'h0 |-> opa == other_status_in[0])
    else $error("operand select wrong");

  // ---------------------------------------------------------------------------
  // Watchdog, response and output checks
  // ---------------------------------------------------------------------------
  a_serial_early_off: assert property (st.ser_loss |-> $past(ser_expire))
    else $error("serial flag before expiry");
  a_serial_stays_off: assert property (!ser_expire |=> !st.ser_loss)
    else $error("serial flag without expiry");
  a_serial_restart: assert property (serial_frame_in |=> st.ser_cnt == 32'h0000_0000)
    else $error("serial count not restarted");
  a_serial_count_hold: assert property (ser_expire && !serial_frame_in |=> st.ser_cnt == $past(st.ser_cnt))
    else $error("serial count moved after expiry");
  a_serial_disabled: assert property (st.ser_to == 32'h0000_0000 |=> !st.ser_loss)
    else $error("serial flag while disabled");
  a_option_frame_clear: assert property (option_frame_in |=> !st.opt_loss)
    else $error("option flag set after frame");
  a_option_stays_off: assert property (!opt_expire |=> !st.opt_loss)
    else $error("option flag without expiry");
  a_option_count_hold: assert property (opt_expire && !option_frame_in |=> st.opt_cnt == $past(st.opt_cnt))
    else $error("option count moved after expiry");
  a_option_disabled: assert property (st.opt_to == 32'h0000_0000 |=> !st.opt_loss)
    else $error("option flag while disabled");
  a_resp_trip_stop: assert property (st.ser_loss && out_sel == status_mon_pkg::SEL_SERIAL
                                     && resp_sel == 2'b01 |=> resp_out.alarm && resp_out.decel_stop)
    else $error("trip stop response missing");
  a_resp_free_run: assert property (st.ser_loss && out_sel == status_mon_pkg::SEL_SERIAL
                                    && resp_sel == 2'b11 |=> resp_out.coast_stop)
    else $error("coast response missing");
  a_resp_no_trip: assert property (!resp_out.alarm && resp_sel[1] |=> !resp_out.alarm)
    else $error("trip without trip setting");
  a_resp_no_decel: assert property (resp_sel == 2'b00 && !resp_out.decel_stop |=> !resp_out.decel_stop)
    else $error("decel stop on trip setting");
  a_alarm_needs_loss: assert property (!resp_out.alarm && !st.ser_loss |=> !resp_out.alarm)
    else $error("alarm without link loss");
  a_alarm_held: assert property (resp_out.alarm |=> resp_out.alarm)
    else $error("alarm not held");
  a_coast_held: assert property (resp_out.coast_stop |=> resp_out.coast_stop)
    else $error("coast stop not held");
  a_decel_held: assert property (resp_out.decel_stop |=> resp_out.decel_stop)
    else $error("decel stop not held");
  a_combo_and: assert property (st.ctrl[21:20] == 2'b00 |=> st.combo == $past(opa & opb))
    else $error("and wrong");
  a_combo_or: assert property (st.ctrl[21:20] == 2'b01 |=> st.combo == $past(opa | opb))
    else $error("or wrong");
  a_operand_b_pick: assert property (st.ctrl[19:16] == 4'h8 |-> opb == other_status_in[8])
    else $error("second operand select wrong");
  a_status_serial: assert property (out_sel == status_mon_pkg::SEL_SERIAL |=> status_out == $past(st.ser_loss))
    else $error("serial flag not on output");
  a_status_option: assert property (out_sel == status_mon_pkg::SEL_OPTION |=> status_out == $past(st.opt_loss))
    else $error("option flag not on output");
  a_status_light: assert property (out_sel == status_mon_pkg::SEL_LIGHT |=> status_out == $past(st.light))
    else $error("light flag not on output");
  a_light_hold: assert property (current_in == st.thresh |=> st.light == $past(st.light))
    else $error("light flag changed at threshold");

  c_serial_loss: cover property (!st.ser_loss ##1 st.ser_loss);
  c_option_loss: cover property (!st.opt_loss ##1 st.opt_loss);
  c_light_load:  cover property (!st.light ##1 st.light);
  c_irq:         cover property (!irq_out ##1 irq_out);
  c_combo_on:    cover property (out_sel == status_mon_pkg::SEL_COMBO && status_out);

endmodule

// ==== test/net_master_model.sv ====
`timescale 1ns/1ps
module net_master_model (
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       ser_en_in,
  input  wire logic       opt_en_in,
  input  wire logic [7:0] gap_in,
  output logic            serial_frame_out,
  output logic            option_frame_out
);
  logic [7:0] cnt;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt <= 8'h00;
    end else begin
      cnt <= (cnt >= gap_in) ? 8'h00 : cnt + 8'h01;
    end
  end
  assign serial_frame_out = ser_en_in && (cnt == gap_in);
  assign option_frame_out = opt_en_in && (cnt == gap_in);
endmodule

// ==== test/status_output_monitors_tb.sv ====
`timescale 1ns/1ps
module status_output_monitors_tb;
  logic                      clk_in = 1'b0;
  logic                      sys_rst_in = 1'b1;
  logic [7:0]                avs_address_in = 8'h00;
  logic                      avs_read_in = 1'b0;
  logic                      avs_write_in = 1'b0;
  logic [31:0]               avs_writedata_in = 32'h0000_0000;
  logic [31:0]               avs_readdata_out;
  logic                      avs_waitrequest_out;
  logic                      ser_fr, opt_fr, status_out, irq_out;
  logic                      ser_en = 1'b0;
  logic                      opt_en = 1'b0;
  logic [15:0]               current_in = 16'h0000;
  logic [8:0]                other_status_in = 9'h000;
  status_mon_pkg::resp_out_t resp_out;
  logic [63:0]               rd_q[$];
  logic [63:0]               note;
  int                        err_count = 0;
  int                        checked = 0;
  int                        seed = 32'h49e2;
  logic [15:0]               cur [4] = '{16'h00ff, 16'h0100, 16'h0101, 16'h0100};
  logic                      lexp [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

  always #2 clk_in = ~clk_in;

  status_output_monitors #(.TICK(4)) uut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hf),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .serial_frame_in(ser_fr),
    .option_frame_in(opt_fr), .current_in(current_in), .other_status_in(other_status_in),
    .status_out(status_out), .resp_out(resp_out), .irq_out(irq_out));

  net_master_model master (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ser_en_in(ser_en), .opt_en_in(opt_en), .gap_in(8'h02),
    .serial_frame_out(ser_fr), .option_frame_out(opt_fr));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic do_reset();
    sys_rst_in <= 1'b1;
    tick(16);
    sys_rst_in <= 1'b0;
  endtask

  task automatic bus(input logic rd, input logic [7:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    @(posedge clk_in);
    avs_address_in <= addr;
    avs_read_in <= rd;
    avs_write_in <= !rd;
    avs_writedata_in <= data;
    // Held until waitrequest is sampled low at a rising edge
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    if (avs_waitrequest_out !== 1'b0) begin
      err_count++;
      wrap_up();
    end
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input logic [31:0] mask);
    rd_q.push_back({mask, exp});
    bus(1'b1, addr, 32'h0000_0000);
  endtask

  // Read data taken at the edge where waitrequest is low
  always @(posedge clk_in) begin
    if (avs_read_in && avs_waitrequest_out === 1'b0) begin
      note = rd_q.pop_front();
      check("readdata", avs_readdata_out & note[63:32], note[31:0]);
    end
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    logic [3:0] a;
    logic [3:0] b;
    logic [1:0] op;
    logic [8:0] os;
    logic       e;
    logic       al;
    do_reset();
    ser_en <= 1'b1;
    opt_en <= 1'b1;
    rd(status_mon_pkg::ADDR_CTRL, status_mon_pkg::CTRL_RESET, 32'hffff_ffff);
    rd(status_mon_pkg::ADDR_SER_TO, 32'h0000_0000, 32'hffff_ffff);
    rd(status_mon_pkg::ADDR_OPT_TO, 32'h0000_0000, 32'hffff_ffff);
    rd(status_mon_pkg::ADDR_THRESH, 32'h0000_0000, 32'hffff_ffff);
    rd(8'h1c, 32'h0000_0000, 32'hffff_ffff);
    for (int i = 0; i < 8; i++) begin
      a = 4'({$random(seed)} % 9);
      b = 4'({$random(seed)} % 9);
      op = 2'(i);
      os = 9'($random(seed));
      bus(1'b0, status_mon_pkg::ADDR_CTRL, {10'h000, op, b, a, 4'h0, status_mon_pkg::SEL_COMBO});
      other_status_in <= os;
      // Operator code 3 is unused and gives zero
      e = (op == 2'd1) ? (os[a] | os[b]) : (op == 2'd2) ? (os[a] ^ os[b]) :
          (op == 2'd0) ? (os[a] & os[b]) : 1'b0;
      tick(4);
      @(negedge clk_in);
      check("combo", {31'h0, status_out}, {31'h0, e});
      rd(status_mon_pkg::ADDR_STATUS, {28'h0, e, 3'h0}, 32'h0000_0008);
    end
    bus(1'b0, status_mon_pkg::ADDR_CTRL, {24'h0, status_mon_pkg::SEL_LIGHT});
    bus(1'b0, status_mon_pkg::ADDR_THRESH, 32'h0000_0100);
    for (int i = 0; i < 4; i++) begin
      tick(1);
      current_in <= cur[i];
      tick(4);
      @(negedge clk_in);
      check("light", {31'h0, status_out}, {31'h0, lexp[i]});
      check("irq masked", {31'h0, irq_out}, 32'h0000_0000);
    end
    bus(1'b0, status_mon_pkg::ADDR_IRQ_MSK, 32'h0000_0002);
    rd(status_mon_pkg::ADDR_IRQ_ST, 32'h0000_0004, 32'h0000_0007);
    bus(1'b0, status_mon_pkg::ADDR_CTRL, {24'h0, status_mon_pkg::SEL_OPTION});
    bus(1'b0, status_mon_pkg::ADDR_OPT_TO, 32'h0000_0003);
    for (int i = 0; i < 10; i++) begin
      tick(5);
      @(negedge clk_in);
      check("option ok", {31'h0, status_out}, 32'h0000_0000);
    end
    tick(1);
    opt_en <= 1'b0;
    tick(60);
    @(negedge clk_in);
    check("option lost", {31'h0, status_out}, 32'h0000_0001);
    check("irq raised", {31'h0, irq_out}, 32'h0000_0001);
    rd(status_mon_pkg::ADDR_IRQ_ST, 32'h0000_0002, 32'h0000_0002);
    tick(2);
    @(negedge clk_in);
    check("irq cleared", {31'h0, irq_out}, 32'h0000_0000);
    tick(1);
    opt_en <= 1'b1;
    tick(8);
    @(negedge clk_in);
    check("option back", {31'h0, status_out}, 32'h0000_0000);
    for (int r = 0; r < 4; r++) begin
      tick(1);
      do_reset();
      al = (r < 2);
      bus(1'b0, status_mon_pkg::ADDR_CTRL, {22'h0, 2'(r), status_mon_pkg::SEL_SERIAL});
      bus(1'b0, status_mon_pkg::ADDR_SER_TO, 32'h0000_0002);
      tick(40);
      @(negedge clk_in);
      check("serial ok", {31'h0, status_out}, 32'h0000_0000);
      check("no response", {21'h0, resp_out}, 32'h0000_0000);
      tick(1);
      ser_en <= 1'b0;
      tick(40);
      @(negedge clk_in);
      check("serial lost", {31'h0, status_out}, 32'h0000_0001);
      check("response", {21'h0, resp_out}, {21'h0, al, al ? status_mon_pkg::ALARM_CODE_LINK : 8'h00,
        r == 1, r == 0 || r == 3});
      rd(status_mon_pkg::ADDR_STATUS, {20'h0, al ? status_mon_pkg::ALARM_CODE_LINK : 8'h00, 4'h1},
        32'h0000_0ff1);
      tick(1);
      ser_en <= 1'b1;
    end
    wrap_up();
  end
endmodule
